// File: core/cmi_map.svh
// Register offsets, field positions and reset values of the compare match interrupt block
`ifndef CMI_MAP_SVH
`define CMI_MAP_SVH

// ==========================================================
// Byte offsets inside the slave window
`define CMI_CTRL_OFF      8'h00
`define CMI_ENABLE_OFF    8'h04
`define CMI_STATUS_OFF    8'h08
`define CMI_CLEAR_OFF     8'h0C
`define CMI_SPRE_TAG      3'h1
`define CMI_MPRE_TAG      1'h1

// ==========================================================
// Control word fields
`define CMI_CTRL_GEN_BIT  0
`define CMI_CTRL_MODE_BIT 1
`define CMI_CTRL_SEL_LSB  4

// ==========================================================
// Reset values
`define CMI_CTRL_RST      32'h0000_0000
`define CMI_ENABLE_RST    8'h00
`define CMI_PRESET_RST    32'h0000_0000

`endif

// File: core/cmi_pkg.sv
// Types and shared helpers of the compare match interrupt block
package cmi_pkg;

  typedef enum logic {CMI_SINGLE, CMI_MULTI} cmi_mode_e;
  typedef enum logic {CMI_IDLE, CMI_DATA} cmi_bus_e;

  // Lane of value y of multi channel ch inside the 32-lane compare array
  function automatic logic [4:0] cmi_lane(input logic [1:0] ch, input logic [2:0] y);
    return {ch, y};
  endfunction

endpackage

// File: core/cmi_match_if.sv
// Carrier between the top and one compare array
`timescale 1ns/1ps
interface cmi_match_if #(
  parameter int N = 8,
  parameter int W = 32
);
  logic [W-1:0] cur [N];
  logic [W-1:0] pre [N];
  logic [N-1:0] hit;
  logic [1:0]   sel;
  logic [7:0]   line;

  modport cmp (input cur, input pre, input sel, output hit, output line);
  modport src (output cur, output pre, output sel, input hit, input line);
endinterface

// File: core/cmi_single_cmp.sv
// Single-value compare array: one match pulse per counting channel
`timescale 1ns/1ps
module cmi_single_cmp
  import cmi_pkg::*;
#(
  parameter int N = 8,
  parameter int W = 32
) (
  input wire logic  hclk,
  input wire logic  hresetn,
  cmi_match_if.cmp  m
);
  logic [N-1:0] eq_prev_r;
  logic [N-1:0] hit_r;
  wire  [N-1:0] eq;

  genvar i;
  for (i = 0; i < N; i++) begin : g_lane
    assign eq[i] = (m.cur[i] == m.pre[i]);
    a_single_edge: assert property (@(posedge hclk) disable iff (!hresetn)
      m.hit[i] |-> ($past(m.cur[i]) == $past(m.pre[i])) ##1 !m.hit[i])
      else $error("single match pulse without equality or longer than one cycle");
  end

  // Pulse once, the cycle after equality appears, so a parked counter does not re-fire
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eq_prev_r <= '0;
      hit_r     <= '0;
    end else begin
      eq_prev_r <= eq;
      hit_r     <= eq & ~eq_prev_r;
    end
  end

  assign m.hit  = hit_r;
  assign m.line = hit_r[7:0];
endmodule // cmi_single_cmp

// File: core/cmi_multi_cmp.sv
// Multi-value compare array: eight values for each of channels 0-3
`timescale 1ns/1ps
module cmi_multi_cmp
  import cmi_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic  hclk,
  input wire logic  hresetn,
  cmi_match_if.cmp  m
);
  logic [31:0] eq_prev_r;
  logic [31:0] hit_r;
  wire  [31:0] eq;

  genvar j;
  for (j = 0; j < 32; j++) begin : g_lane
    assign eq[j] = (m.cur[j] == m.pre[j]);
    a_multi_edge: assert property (@(posedge hclk) disable iff (!hresetn)
      m.hit[j] |-> ($past(m.cur[j]) == $past(m.pre[j])) ##1 !m.hit[j])
      else $error("multi match pulse without equality or longer than one cycle");
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eq_prev_r <= '0;
      hit_r     <= '0;
    end else begin
      eq_prev_r <= eq;
      hit_r     <= eq & ~eq_prev_r;
    end
  end

  // Only the selected channel reaches the lines; value y drives line y
  assign m.hit  = hit_r;
  assign m.line = hit_r[{m.sel, 3'b000} +: 8];
endmodule // cmi_multi_cmp

// File: core/cmi_top.sv
// Compare match interrupt block with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "cmi_map.svh"
module cmi_top
  import cmi_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic      [31:0]    hrdata,
  input  wire logic [8*W-1:0] current_count_value,
  output logic      [7:0]     compare_event_task,
  output logic      [7:0]     single_match_pulse,
  output logic      [31:0]    multi_match_pulse
);

  // ==========================================================
  // Registers
  cmi_bus_e    bus_r;
  logic [7:0]  addr_r;
  logic        wr_r;
  logic        hready_r;
  logic [31:0] hrdata_r;
  logic        gen_r;
  cmi_mode_e   mode_r;
  logic [1:0]  sel_r;
  logic [7:0]  en_r;
  logic [7:0]  irq_r;
  logic [7:0]  irq_nxt;
  logic [W-1:0] spre_r [8];
  logic [W-1:0] mpre_r [32];

  // ==========================================================
  // Compare arrays
  cmi_match_if #(.N(8),  .W(W)) s_if ();
  cmi_match_if #(.N(32), .W(W)) m_if ();

  genvar i;
  for (i = 0; i < 8; i++) begin : g_single
    assign s_if.cur[i] = current_count_value[i*W +: W];
    assign s_if.pre[i] = spre_r[i];
  end
  // Channels 0-3 each feed eight lanes, one per preset value
  for (i = 0; i < 32; i++) begin : g_multi
    assign m_if.cur[i] = current_count_value[(i/8)*W +: W];
    assign m_if.pre[i] = mpre_r[i];
  end
  assign s_if.sel = sel_r;
  assign m_if.sel = sel_r;

  cmi_single_cmp #(.N(8), .W(W)) u_single (
    .hclk    (hclk),
    .hresetn (hresetn),
    .m       (s_if)
  );

  cmi_multi_cmp #(.W(W)) u_multi (
    .hclk    (hclk),
    .hresetn (hresetn),
    .m       (m_if)
  );

  // ==========================================================
  // Bus decode
  wire        take     = hsel & htrans[1] & hready;
  wire        data_ph  = (bus_r == CMI_DATA);
  wire        wr_go    = data_ph & wr_r;
  wire        hit_ctrl = (addr_r == `CMI_CTRL_OFF);
  wire        hit_en   = (addr_r == `CMI_ENABLE_OFF);
  wire        hit_stat = (addr_r == `CMI_STATUS_OFF);
  wire        hit_clr  = (addr_r == `CMI_CLEAR_OFF);
  wire        hit_spre = (addr_r[7:5] == `CMI_SPRE_TAG);
  wire        hit_mpre = (addr_r[7] == `CMI_MPRE_TAG);
  wire [2:0]  spre_idx = addr_r[4:2];
  wire [4:0]  mpre_idx = cmi_lane(addr_r[6:5], addr_r[4:2]);
  wire [31:0] ctrl_word = (32'(gen_r) << `CMI_CTRL_GEN_BIT)
                        | (32'(mode_r) << `CMI_CTRL_MODE_BIT)
                        | (32'(sel_r) << `CMI_CTRL_SEL_LSB);
  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_en   ? {24'h0, en_r} :
                       hit_stat ? {24'h0, irq_r} :
                       hit_spre ? 32'(spre_r[spre_idx]) :
                       hit_mpre ? 32'(mpre_r[mpre_idx]) : 32'h0000_0000;

  // ==========================================================
  // Interrupt state
  wire [7:0] clr_vec  = (wr_go & hit_clr) ? hwdata[7:0] : 8'h00;
  wire [7:0] src_line = (mode_r == CMI_MULTI) ? m_if.line : s_if.line;
  wire [7:0] set_vec  = {8{gen_r}} & en_r & src_line;

  // Set beats clear; dropping the global enable wipes all lines
  assign irq_nxt = gen_r ? ((irq_r & ~clr_vec) | set_vec) : 8'h00;

  // ==========================================================
  // Bus state machine: one wait state so read data comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_r    <= CMI_IDLE;
      addr_r   <= 8'h00;
      wr_r     <= 1'b0;
      hready_r <= 1'b1;
      hrdata_r <= 32'h0000_0000;
    end else begin
      case (bus_r)
        CMI_IDLE: begin
          if (take) begin
            bus_r    <= CMI_DATA;
            addr_r   <= haddr[7:0];
            wr_r     <= hwrite;
            hready_r <= 1'b0;
          end
        end
        CMI_DATA: begin
          bus_r    <= CMI_IDLE;
          hready_r <= 1'b1;
          if (!wr_r) begin
            hrdata_r <= rd_mux;
          end
        end
        default: begin
          bus_r    <= CMI_IDLE;
          hready_r <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Control and preset registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gen_r  <= 1'(`CMI_CTRL_RST >> `CMI_CTRL_GEN_BIT);
      mode_r <= CMI_SINGLE;
      sel_r  <= 2'h0;
      en_r   <= `CMI_ENABLE_RST;
    end else if (wr_go & hit_ctrl) begin
      gen_r  <= hwdata[`CMI_CTRL_GEN_BIT];
      mode_r <= cmi_mode_e'(hwdata[`CMI_CTRL_MODE_BIT]);
      sel_r  <= hwdata[`CMI_CTRL_SEL_LSB +: 2];
    end else if (wr_go & hit_en) begin
      en_r   <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < 8; k++) begin
        spre_r[k] <= W'(`CMI_PRESET_RST);
      end
      for (int k = 0; k < 32; k++) begin
        mpre_r[k] <= W'(`CMI_PRESET_RST);
      end
    end else if (wr_go & hit_spre) begin
      spre_r[spre_idx] <= W'(hwdata);
    end else if (wr_go & hit_mpre) begin
      mpre_r[mpre_idx] <= W'(hwdata);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 8'h00;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout          = hready_r;
  assign hresp              = 1'b0;
  assign hrdata             = hrdata_r;
  assign compare_event_task = irq_r;
  assign single_match_pulse = s_if.hit;
  assign multi_match_pulse  = m_if.hit;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Line history flop: the rising-line checks need last cycle's state as a plain signal
  logic [7:0] irq_prev_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_prev_r <= 8'h00;
    end else begin
      irq_prev_r <= irq_r;
    end
  end

  wire [7:0] new_irq  = compare_event_task & ~irq_prev_r;
  wire [7:0] both_hit = set_vec & clr_vec;
  wire [7:0] drop_vec = clr_vec & ~set_vec;
  wire       rd_go    = data_ph & ~wr_r;

  sequence s_addr_taken;
    take && (bus_r == CMI_IDLE);
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_bus_wait_state: assert property (s_addr_taken |=> s_one_wait)
    else $error("slave did not answer after exactly one wait state");

  a_set_beats_clr: assert property ((|both_hit) |=> ((irq_r & $past(both_hit)) == $past(both_hit)))
    else $error("clear overrode a same-cycle match");

  a_global_gate: assert property (!gen_r |=> (compare_event_task == 8'h00))
    else $error("line high while global enable clear");

  a_enable_gate: assert property ((new_irq & ~$past(en_r)) == 8'h00)
    else $error("line set without its enable bit");

  a_single_set: assert property (((mode_r == CMI_SINGLE) && gen_r)
    |=> ((irq_r & $past(en_r & s_if.line)) == $past(en_r & s_if.line)))
    else $error("enabled single match did not set its line");

  a_multi_set: assert property (((mode_r == CMI_MULTI) && gen_r)
    |=> ((irq_r & $past(en_r & m_if.line)) == $past(en_r & m_if.line)))
    else $error("enabled multi match did not set its line");

  a_hold_until_clr: assert property (gen_r
    |=> (!gen_r || (($past(irq_r) & ~$past(clr_vec) & ~irq_r) == 8'h00)))
    else $error("line dropped without a clear");

  a_multi_source: assert property (($past(mode_r) == CMI_MULTI)
    |-> ((new_irq & ~$past(m_if.hit[{sel_r, 3'b000} +: 8])) == 8'h00))
    else $error("multi line set by an unselected channel or value");

  a_sel_hold: assert property (!(wr_go && hit_ctrl) |=> $stable(sel_r))
    else $error("multi source changed without a control write");

  // ==========================================================
  // Checks on register access
  a_okay_only: assert property (hresp == 1'b0)
    else $error("slave answered with a response other than okay");

  a_rdata_hold: assert property (!rd_go |=> $stable(hrdata))
    else $error("read data changed outside a read data phase");

  a_status_read: assert property ((rd_go && hit_stat)
    |=> (hrdata == {24'h0, $past(irq_r)}))
    else $error("status read did not return the line state");

  // Clear is write-only; a read must not leak the last cleared mask
  a_clear_reads_zero: assert property ((rd_go && hit_clr) |=> (hrdata == 32'h0000_0000))
    else $error("clear register read back nonzero");

  a_ctrl_write: assert property ((wr_go && hit_ctrl)
    |=> ((gen_r == $past(hwdata[`CMI_CTRL_GEN_BIT]))
         && (sel_r == $past(hwdata[`CMI_CTRL_SEL_LSB +: 2]))))
    else $error("control write did not land");

  a_enable_write: assert property ((wr_go && hit_en)
    |=> (en_r == $past(hwdata[7:0])))
    else $error("enable write did not land");

  a_spre_write: assert property ((wr_go && hit_spre)
    |=> (spre_r[$past(spre_idx)] == $past(hwdata)))
    else $error("single preset write did not land");

  a_mpre_write: assert property ((wr_go && hit_mpre)
    |=> (mpre_r[$past(mpre_idx)] == $past(hwdata)))
    else $error("multi preset write did not land");

  // ==========================================================
  // Checks on line clearing and source selection
  a_clear_drops: assert property ((gen_r && (|drop_vec))
    |=> ((irq_r & $past(drop_vec)) == 8'h00))
    else $error("cleared line stayed set");

  // Multi lanes must never reach the lines while single mode is chosen
  a_single_only: assert property (($past(mode_r) == CMI_SINGLE)
    |-> ((new_irq & ~$past(s_if.line)) == 8'h00))
    else $error("single mode line set without its channel match");

endmodule // cmi_top

// File: tb/cmi_host.sv
// Host model: AHB-Lite master that programs and services the block
`timescale 1ns/1ps
module cmi_host (
  input  wire logic        hclk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  logic tmo;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tmo = 1'b0;
  end
  // ====================
  // Bus cycle
  // Ready is sampled at the edge; a stuck slave raises tmo
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) tmo = 1'b1;
  endtask
  // The select field is always written whole, so one multi source is named
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~{24'h0, a};
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule // cmi_host

// File: tb/tb_cmi_top.sv
// Self-checking bench of the compare match interrupt block
`timescale 1ns/1ps
`include "cmi_map.svh"
module tb_cmi_top;
  logic         hclk;
  logic         hresetn;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata;
  logic [255:0] cv;
  logic [7:0]   compare_event_task;
  logic [7:0]   single_match_pulse;
  logic [31:0]  multi_match_pulse;
  int           mismatches;
  int           num_checks;

  always #5 hclk = ~hclk;

  cmi_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .current_count_value(cv), .compare_event_task(compare_event_task),
    .single_match_pulse(single_match_pulse), .multi_match_pulse(multi_match_pulse));
  cmi_host u_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ====================
  // Helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    u_host.xfer(w, a, d, q);
    if (u_host.tmo) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check($sformatf("register %h", a), q, exp);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask
  // Count leaves the preset for a cycle so equality rises again
  task automatic hit(input int ch, input logic [31:0] v, input logic [7:0] esp,
                     input logic [31:0] emp, input logic [7:0] eev);
    cv[ch*32 +: 32] <= ~v;
    @(posedge hclk);
    cv[ch*32 +: 32] <= v;
    @(posedge hclk);
    #1;
    check("single_match_pulse", {24'h0, single_match_pulse}, {24'h0, esp});
    check("multi_match_pulse", multi_match_pulse, emp);
    @(posedge hclk);
    #1;
    check("compare_event_task", {24'h0, compare_event_task}, {24'h0, eev});
    @(posedge hclk);
  endtask

  // ====================
  // Scenarios
  task automatic t_reset();
    check("compare_event_task", {24'h0, compare_event_task}, 32'h0);
    rd_chk(`CMI_CTRL_OFF, `CMI_CTRL_RST);
    rd_chk(`CMI_ENABLE_OFF, {24'h0, `CMI_ENABLE_RST});
    rd_chk(`CMI_CLEAR_OFF, 32'h0);
    rd_chk(8'h10, 32'h0);
  endtask
  task automatic t_single();
    logic [7:0] e;
    e = 8'h00;
    for (int x = 0; x < 8; x++) wr(8'h20 + 8'(4 * x), 32'h64 + 32'(x));
    wr(`CMI_ENABLE_OFF, 32'hFF);
    wr(`CMI_CTRL_OFF, 32'h1);
    for (int x = 0; x < 8; x++) begin
      e = e | (8'h01 << x);
      hit(x, 32'h64 + 32'(x), 8'h01 << x, 32'h0, e);
    end
    rd_chk(`CMI_STATUS_OFF, 32'hFF);
    wr(`CMI_CLEAR_OFF, 32'hFF);
    rd_chk(`CMI_STATUS_OFF, 32'h0);
  endtask
  task automatic t_gate();
    wr(`CMI_ENABLE_OFF, 32'h0F);
    rd_chk(`CMI_ENABLE_OFF, 32'h0F);
    hit(5, 32'h69, 8'h20, 32'h0, 8'h00);
    hit(1, 32'h65, 8'h02, 32'h0, 8'h02);
    wr(`CMI_CTRL_OFF, 32'h0);
    rd_chk(`CMI_STATUS_OFF, 32'h0);
    hit(1, 32'h65, 8'h02, 32'h0, 8'h00);
  endtask
  task automatic t_multi();
    logic [7:0] e;
    e = 8'h00;
    for (int y = 0; y < 8; y++) wr(8'h80 + 8'(4 * (16 + y)), 32'hC8 + 32'(y));
    wr(8'hAC, 32'h12C);
    wr(`CMI_ENABLE_OFF, 32'hFF);
    wr(`CMI_CTRL_OFF, 32'h23);
    for (int y = 0; y < 8; y++) begin
      e = e | (8'h01 << y);
      hit(2, 32'hC8 + 32'(y), 8'h00, 32'h1 << (16 + y), e);
    end
    hit(1, 32'h12C, 8'h00, 32'h800, 8'hFF);
    hit(3, 32'h67, 8'h08, 32'h0, 8'hFF);
  endtask
  // Match and clear land on the same edge; line 0 must survive
  task automatic t_race();
    cv[64 +: 32] <= 32'hC8;
    wr(`CMI_CLEAR_OFF, 32'h3);
    rd_chk(`CMI_STATUS_OFF, 32'hFD);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    cv = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_single();
    t_gate();
    t_multi();
    t_race();
    test_done();
  end
endmodule // tb_cmi_top
